// ===== include/pci_irq_router_cfg.svh
`ifndef PCI_IRQ_ROUTER_CFG_SVH
`define PCI_IRQ_ROUTER_CFG_SVH

// I/O port addresses
`define IRQR_INDEX_ADDR 16'h0c00
`define IRQR_DATA_ADDR 16'h0c01

// Indirect register indices behind the data port
`define IRQR_IDX_ROUTE_LAST 8'h0f
`define IRQR_IDX_MODE 8'h10
`define IRQR_IDX_APIC0_MASK_LO 8'h20
`define IRQR_IDX_APIC0_MASK_HI 8'h21
`define IRQR_IDX_APIC1_MASK_LO 8'h22
`define IRQR_IDX_APIC1_MASK_HI 8'h23
`define IRQR_IDX_PIC_MASK_LO 8'h30
`define IRQR_IDX_PIC_MASK_HI 8'h31

// Mode register fields
`define IRQR_MODE_LSB 0
`define IRQR_MODE_MSB 1
`define IRQR_MODE_SECOND_APIC_BIT 2

// Route field: 0 means unmapped, otherwise the legacy line number
`define IRQR_ROUTE_W 4
`define IRQR_ROUTE_NONE 4'h0

// The 11 legacy lines a PCI input may be steered to
`define IRQR_ALLOWED_LINES 16'hdef8

// Reset values
`define IRQR_INDEX_RST 8'h00
`define IRQR_APIC_MASK_RST 16'hffff
`define IRQR_PIC_MASK_RST 16'hffff

// Slave controller cascades into master line 2
`define IRQR_CASCADE_LINE 2

`endif

// ===== include/pci_irq_router_pkg.sv
package pci_irq_router_pkg;

    typedef enum logic [1:0] {
        MODE_LEGACY,
        MODE_VWIRE,
        MODE_SMP
    } irq_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic cpu_intr;
        logic lint0_intr;
        logic pend_valid;
        logic [3:0] pend_line;
    } cpu_irq_t;

endpackage : pci_irq_router_pkg

// ===== verilog/pci_irq_router.sv
`timescale 1ns/1ps
`include "pci_irq_router_cfg.svh"
module pci_irq_router #(
    parameter int N_PCI = 16,
    parameter int N_ISA = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire pci_irq_router_pkg::io_req_t io_req,
    output logic [7:0] io_rdata,
    input wire logic [N_PCI-1:0] pci_irq,
    output logic [N_ISA-1:0] isa_irq,
    output logic [N_PCI-1:0] apic0_irq,
    output logic [N_ISA-1:0] apic1_irq,
    output pci_irq_router_pkg::cpu_irq_t cpu_irq
);

    localparam logic [N_ISA-1:0] ALLOWED = N_ISA'(`IRQR_ALLOWED_LINES);

    logic [7:0] index_reg;
    logic [`IRQR_ROUTE_W-1:0] route_reg [N_PCI];
    pci_irq_router_pkg::irq_mode_t mode_reg;
    logic second_apic_config;
    logic [15:0] apic0_mask_reg;
    logic [15:0] apic1_mask_reg;
    logic [15:0] pic_mask_reg;

    logic wr_index;
    logic wr_data;
    logic rd_any;
    logic [N_ISA-1:0] hit [N_PCI];
    logic [N_ISA-1:0] isa_next;
    logic [N_ISA-1:0] pic_req;
    logic [7:0] data_next;
    logic [3:0] pend_line_next;
    logic pend_valid_next;
    logic [`IRQR_ROUTE_W-1:0] wr_route;

    assign wr_index = io_req.wr && io_req.addr == `IRQR_INDEX_ADDR;
    assign wr_data = io_req.wr && io_req.addr == `IRQR_DATA_ADDR;
    assign rd_any = io_req.rd && (io_req.addr == `IRQR_INDEX_ADDR ||
                                  io_req.addr == `IRQR_DATA_ADDR);
    // A write naming a line outside the allowed set leaves the input unmapped
    assign wr_route = ALLOWED[io_req.wdata[`IRQR_ROUTE_W-1:0]] ?
                      io_req.wdata[`IRQR_ROUTE_W-1:0] : `IRQR_ROUTE_NONE;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            index_reg <= `IRQR_INDEX_RST;
        end else if (wr_index) begin
            index_reg <= io_req.wdata;
        end
    end

    // Route table: one entry per PCI input, cleared at reset
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < N_PCI; i++) begin
                route_reg[i] <= `IRQR_ROUTE_NONE;
            end
        end else if (wr_data && index_reg <= `IRQR_IDX_ROUTE_LAST) begin
            route_reg[index_reg[3:0]] <= wr_route;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mode_reg <= pci_irq_router_pkg::MODE_LEGACY;
            second_apic_config <= 1'b0;
        end else if (wr_data && index_reg == `IRQR_IDX_MODE) begin
            // Encoding 3 is not a mode; the old mode is kept
            case (io_req.wdata[`IRQR_MODE_MSB:`IRQR_MODE_LSB])
                2'h0: mode_reg <= pci_irq_router_pkg::MODE_LEGACY;
                2'h1: mode_reg <= pci_irq_router_pkg::MODE_VWIRE;
                2'h2: mode_reg <= pci_irq_router_pkg::MODE_SMP;
                default: mode_reg <= mode_reg;
            endcase
            second_apic_config <= io_req.wdata[`IRQR_MODE_SECOND_APIC_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            apic0_mask_reg <= `IRQR_APIC_MASK_RST;
            apic1_mask_reg <= `IRQR_APIC_MASK_RST;
            pic_mask_reg <= `IRQR_PIC_MASK_RST;
        end else if (wr_data) begin
            if (index_reg == `IRQR_IDX_APIC0_MASK_LO) begin
                apic0_mask_reg[7:0] <= io_req.wdata;
            end else if (index_reg == `IRQR_IDX_APIC0_MASK_HI) begin
                apic0_mask_reg[15:8] <= io_req.wdata;
            end else if (index_reg == `IRQR_IDX_APIC1_MASK_LO) begin
                apic1_mask_reg[7:0] <= io_req.wdata;
            end else if (index_reg == `IRQR_IDX_APIC1_MASK_HI) begin
                apic1_mask_reg[15:8] <= io_req.wdata;
            end else if (index_reg == `IRQR_IDX_PIC_MASK_LO) begin
                pic_mask_reg[7:0] <= io_req.wdata;
            end else if (index_reg == `IRQR_IDX_PIC_MASK_HI) begin
                pic_mask_reg[15:8] <= io_req.wdata;
            end
        end
    end

    // Per-input decode; an unmasked APIC entry takes the input away from
    // the legacy lines so the OS can hand over from PIC to APIC cleanly
    for (genvar i = 0; i < N_PCI; i++) begin : g_route
        always_comb begin
            hit[i] = '0;
            if (pci_irq[i] && apic0_mask_reg[i] &&
                route_reg[i] != `IRQR_ROUTE_NONE) begin
                hit[i][route_reg[i]] = 1'b1;
            end
        end
    end

    always_comb begin
        isa_next = '0;
        for (int i = 0; i < N_PCI; i++) begin
            isa_next = isa_next | hit[i];
        end
    end

    // Master and slave controller: lowest line wins, the slave's lines
    // take the priority of the cascade input on the master
    assign pic_req = isa_next & ~pic_mask_reg;
    always_comb begin
        pend_valid_next = 1'b0;
        pend_line_next = 4'h0;
        for (int m = 7; m >= 0; m--) begin
            if (m == `IRQR_CASCADE_LINE && |pic_req[15:8]) begin
                pend_valid_next = 1'b1;
                for (int s = 15; s >= 8; s--) begin
                    if (pic_req[s]) begin
                        pend_line_next = 4'(s);
                    end
                end
            end else if (pic_req[m]) begin
                pend_valid_next = 1'b1;
                pend_line_next = 4'(m);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            isa_irq <= '0;
            cpu_irq <= '0;
        end else begin
            isa_irq <= isa_next;
            cpu_irq.pend_valid <= pend_valid_next;
            cpu_irq.pend_line <= pend_line_next;
            // Legacy drives INTR directly, virtual wire through LINT0
            cpu_irq.cpu_intr <= pend_valid_next &&
                mode_reg == pci_irq_router_pkg::MODE_LEGACY;
            cpu_irq.lint0_intr <= pend_valid_next &&
                mode_reg == pci_irq_router_pkg::MODE_VWIRE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            apic0_irq <= '0;
            apic1_irq <= '0;
        end else begin
            apic0_irq <= pci_irq & ~apic0_mask_reg;
            apic1_irq <= second_apic_config ?
                         (isa_next & ~apic1_mask_reg) : '0;
        end
    end

    always_comb begin
        data_next = 8'h00;
        if (io_req.addr == `IRQR_INDEX_ADDR) begin
            data_next = index_reg;
        end else if (index_reg <= `IRQR_IDX_ROUTE_LAST) begin
            data_next = 8'(route_reg[index_reg[3:0]]);
        end else if (index_reg == `IRQR_IDX_MODE) begin
            data_next = {5'h00, second_apic_config, mode_reg};
        end else if (index_reg == `IRQR_IDX_APIC0_MASK_LO) begin
            data_next = apic0_mask_reg[7:0];
        end else if (index_reg == `IRQR_IDX_APIC0_MASK_HI) begin
            data_next = apic0_mask_reg[15:8];
        end else if (index_reg == `IRQR_IDX_APIC1_MASK_LO) begin
            data_next = apic1_mask_reg[7:0];
        end else if (index_reg == `IRQR_IDX_APIC1_MASK_HI) begin
            data_next = apic1_mask_reg[15:8];
        end else if (index_reg == `IRQR_IDX_PIC_MASK_LO) begin
            data_next = pic_mask_reg[7:0];
        end else if (index_reg == `IRQR_IDX_PIC_MASK_HI) begin
            data_next = pic_mask_reg[15:8];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            io_rdata <= 8'h00;
        end else if (rd_any) begin
            io_rdata <= data_next;
        end else begin
            io_rdata <= 8'h00;
        end
    end

    logic route_bad;
    always_comb begin
        route_bad = 1'b0;
        for (int i = 0; i < N_PCI; i++) begin
            if (route_reg[i] != `IRQR_ROUTE_NONE && !ALLOWED[route_reg[i]]) begin
                route_bad = 1'b1;
            end
        end
    end

    property p_reset_unmapped;
        @(posedge sys_clk) $past(!nrst) && nrst |-> isa_irq == '0;
    endproperty
    a_reset_unmapped: assert property (p_reset_unmapped)
        else $error("legacy lines active right after reset");

    property p_index_write;
        @(posedge sys_clk) disable iff (!nrst)
        wr_index |=> index_reg == $past(io_req.wdata);
    endproperty
    a_index_write: assert property (p_index_write)
        else $error("index register did not take the write");

    property p_route_allowed;
        @(posedge sys_clk) disable iff (!nrst) !route_bad;
    endproperty
    a_route_allowed: assert property (p_route_allowed)
        else $error("route holds a line outside the allowed set");

    property p_mask_gates;
        @(posedge sys_clk) disable iff (!nrst)
        (pci_irq & apic0_mask_reg) == '0 |=> isa_irq == '0;
    endproperty
    a_mask_gates: assert property (p_mask_gates)
        else $error("legacy line driven by an unmasked APIC input");

    property p_apic0_pass;
        @(posedge sys_clk) disable iff (!nrst)
        nrst |=> apic0_irq == $past(pci_irq & ~apic0_mask_reg);
    endproperty
    a_apic0_pass: assert property (p_apic0_pass)
        else $error("default APIC output does not follow inputs");

    property p_apic1_off;
        @(posedge sys_clk) disable iff (!nrst)
        !second_apic_config |=> apic1_irq == '0;
    endproperty
    a_apic1_off: assert property (p_apic1_off)
        else $error("second APIC active outside extended config");

    property p_smp_quiet;
        @(posedge sys_clk) disable iff (!nrst)
        mode_reg == pci_irq_router_pkg::MODE_SMP |=>
            !cpu_irq.cpu_intr && !cpu_irq.lint0_intr;
    endproperty
    a_smp_quiet: assert property (p_smp_quiet)
        else $error("legacy interrupt seen in symmetric mode");

    property p_legacy_intr;
        @(posedge sys_clk) disable iff (!nrst)
        mode_reg == pci_irq_router_pkg::MODE_LEGACY && pic_req != '0
            |=> cpu_irq.cpu_intr && !cpu_irq.lint0_intr;
    endproperty
    a_legacy_intr: assert property (p_legacy_intr)
        else $error("legacy request did not reach the processor");

    property p_single_route;
        @(posedge sys_clk) disable iff (!nrst)
        pci_irq == 16'h0001 && apic0_mask_reg[0] &&
            route_reg[0] == 4'hb |=> isa_irq == 16'h0800;
    endproperty
    a_single_route: assert property (p_single_route)
        else $error("single input not translated to its line");

endmodule : pci_irq_router

// ===== test/pci_dev_model.sv
`timescale 1ns/1ps
module pci_dev_model (
    input wire logic sys_clk,
    output logic [15:0] pci_irq
);
    initial begin
        pci_irq = 16'h0000;
    end

    // Levels move only just after an edge, never on the sampling edge
    task automatic drive(input logic [15:0] lvl);
        @(posedge sys_clk);
        pci_irq <= lvl;
    endtask : drive
endmodule : pci_dev_model

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "pci_irq_router_cfg.svh"
module testbench;
    logic sys_clk;
    logic nrst;
    pci_irq_router_pkg::io_req_t io_req;
    pci_irq_router_pkg::cpu_irq_t cpu_irq;
    logic [7:0] io_rdata;
    logic [15:0] pci_irq, isa_irq, apic0_irq, apic1_irq;
    logic [15:0] ok_lines = `IRQR_ALLOWED_LINES;
    logic [7:0] d;
    int err_total;
    int n_compared;

    pci_irq_router dut_u (.sys_clk(sys_clk), .nrst(nrst), .io_req(io_req),
        .io_rdata(io_rdata), .pci_irq(pci_irq), .isa_irq(isa_irq),
        .apic0_irq(apic0_irq), .apic1_irq(apic1_irq), .cpu_irq(cpu_irq));
    pci_dev_model model_u (.sys_clk(sys_clk), .pci_irq(pci_irq));

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Strobe drops after one cycle, so back-to-back calls leave a gap
    task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        io_req <= '{addr: a, wr: 1'h1, rd: 1'h0, wdata: v};
        @(posedge sys_clk);
        io_req.wr <= 1'h0;
    endtask : io_wr

    task automatic io_rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        io_req <= '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
        @(posedge sys_clk);
        io_req.rd <= 1'h0;
        #1;
        v = io_rdata;
    endtask : io_rd

    task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
        io_wr(`IRQR_INDEX_ADDR, idx);
        io_wr(`IRQR_DATA_ADDR, v);
    endtask : wreg

    task automatic chk_reg(input string what, input logic [7:0] idx,
                           input logic [7:0] exp);
        io_wr(`IRQR_INDEX_ADDR, idx);
        io_rd(`IRQR_DATA_ADDR, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask : chk_reg

    task automatic irq(input logic [15:0] v);
        model_u.drive(v);
        @(posedge sys_clk);
        #1;
    endtask : irq

    task automatic conclude();
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #40000;
        err_total++;
        conclude();
    end

    initial begin
        nrst = 1'h0;
        io_req = '0;
        err_total = 0;
        n_compared = 0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'h1;
        check("isa reset", isa_irq, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            chk_reg("route reset", 8'(i), 8'h00);
        end
        io_rd(16'h0c02, d);
        check("unmapped port", {8'h00, d}, 16'h0000);
        io_rd(`IRQR_INDEX_ADDR, d);
        check("index readback", {8'h00, d}, 16'h000f);
        chk_reg("apic0 mask", `IRQR_IDX_APIC0_MASK_LO, 8'hff);
        for (int v = 0; v < 16; v++) begin
            wreg(8'h00, 8'(v));
            chk_reg("route value", 8'h00, ok_lines[v] ? 8'(v) : 8'h00);
        end
        wreg(8'h00, 8'h0b);
        wreg(8'h01, 8'h03);
        wreg(8'h02, 8'h03);
        wreg(`IRQR_IDX_PIC_MASK_HI, 8'hf7);
        irq(16'h0007);
        check("isa routed", isa_irq, 16'h0808);
        check("apic0 masked", apic0_irq, 16'h0000);
        check("pend line", {12'h000, cpu_irq.pend_line}, 16'h000b);
        // Slave lines outrank master lines 3..7 through the cascade input
        wreg(`IRQR_IDX_PIC_MASK_LO, 8'hf7);
        irq(16'h0007);
        check("pend cascade", {12'h000, cpu_irq.pend_line}, 16'h000b);
        irq(16'h0001);
        check("isa single", isa_irq, 16'h0800);
        check("pend valid", {15'h0, cpu_irq.pend_valid}, 16'h0001);
        for (int m = 0; m < 3; m++) begin
            wreg(`IRQR_IDX_MODE, 8'(m));
            @(posedge sys_clk);
            #1;
            check("cpu intr", {15'h0, cpu_irq.cpu_intr}, {15'h0, m == 0});
            check("lint0", {15'h0, cpu_irq.lint0_intr}, {15'h0, m == 1});
        end
        wreg(`IRQR_IDX_MODE, 8'h03);
        chk_reg("mode keep", `IRQR_IDX_MODE, 8'h02);
        wreg(`IRQR_IDX_APIC1_MASK_HI, 8'h00);
        irq(16'h0007);
        check("apic1 off", apic1_irq, 16'h0000);
        wreg(`IRQR_IDX_MODE, 8'h06);
        irq(16'h0007);
        check("apic1 on", apic1_irq, 16'h0800);
        wreg(`IRQR_IDX_APIC0_MASK_LO, 8'hfe);
        irq(16'h0007);
        check("isa unmasked", isa_irq, 16'h0008);
        check("apic0 deliver", apic0_irq, 16'h0001);
        irq(16'h0000);
        check("isa release", isa_irq, 16'h0000);
        check("pend clear", {15'h0, cpu_irq.pend_valid}, 16'h0000);
        // Reset in mid-run must drop every programmed route and mask
        @(posedge sys_clk);
        nrst <= 1'h0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        chk_reg("route rerun", 8'h00, 8'h00);
        chk_reg("mode rerun", `IRQR_IDX_MODE, 8'h00);
        chk_reg("mask rerun", `IRQR_IDX_APIC0_MASK_LO, 8'hff);
        conclude();
    end
endmodule : testbench
